/* cid_params.svh */
// offsets, field positions, opcodes and reset values for the instruction slice
// assumes inclusion by bare name from the core, its checker and the bench
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// register offsets (byte addresses, one word each)
`define CID_OFF_CTRL    8'h00
`define CID_OFF_STATUS  8'h04
`define CID_OFF_PC      8'h08
`define CID_OFF_SP      8'h0C
`define CID_OFF_IP      8'h10
`define CID_OFF_FLAGS   8'h14
`define CID_OFF_MODE    8'h18
`define CID_OFF_WIN     8'h1C
`define CID_OFF_RFADDR  8'h20
`define CID_OFF_RFDATA  8'h24

// status bit positions
`define CID_ST_BUSY     0
`define CID_ST_IDLE     1
`define CID_ST_TAKEN    2
`define CID_ST_BADOP    3
`define CID_ST_PEND     4

// flags and system mode fields
`define CID_FLG_Z       6
`define CID_FLG_S       5
`define CID_FLG_V       4
`define CID_MODE_IRQ_EN 0

// opcodes
`define CID_OP_ENTER    8'h1F
`define CID_OP_EXIT     8'h2F
`define CID_OP_IDLE     8'h6F
`define CID_OP_IRQ_ON   8'h9F
`define CID_OP_INC_R    8'h20
`define CID_OP_INC_IR   8'h21
`define CID_OP_WORD_RR  8'hA0
`define CID_OP_WORD_IR  8'hA1
`define CID_NIB_LOOP    4'hA
`define CID_NIB_INC     4'hE

// steps and lengths
`define CID_LEN1        16'h0001
`define CID_LEN2        16'h0002
`define CID_SP_STEP     8'h02

// reset values
`define CID_RST_PC      16'h0000
`define CID_RST_SP      8'h00
`define CID_RST_IP      16'h0000
`define CID_RST_FLAGS   8'h00
`define CID_RST_MODE    8'h00
`define CID_RST_WIN     8'h00

`endif

/* cid_pkg.sv */
// types shared by the instruction slice core
// assumes no other package
package cid_pkg;

    typedef enum logic [12:0] {
        ST_READY  = 13'h0001,
        ST_IND    = 13'h0002,
        ST_INDW   = 13'h0004,
        ST_RD1    = 13'h0008,
        ST_RD2    = 13'h0010,
        ST_CALC   = 13'h0020,
        ST_WR2    = 13'h0040,
        ST_PUSH1  = 13'h0080,
        ST_PUSH2  = 13'h0100,
        ST_POP1   = 13'h0200,
        ST_POP2   = 13'h0400,
        ST_POP3   = 13'h0800,
        ST_PMWAIT = 13'h1000
    } cid_state_t;

    typedef struct packed {
        logic [7:0] arg;
        logic [7:0] op;
    } cid_instr_t;

    typedef struct packed {
        logic [15:0] res;
        logic        zero;
        logic        neg;
        logic        ovf;
    } cid_alu_t;

endpackage

/* cid_regfile.sv */
// byte register file with registered read data
// assumes one port, read-during-write returns old data
`timescale 1ns/1ps
module cid_regfile #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rst_b_i,
    input  wire logic          ce_i,
    // access port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge mclk_i) begin
        if (ce_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule // cid_regfile

/* cid_core.sv */
// loop-branch, interrupt enable, threaded enter/exit, idle and increment slice
// assumes an apb master on mclk_i and a program memory answering pm_req_o with pm_ack_i
//
// How it works
// - loop-branch decrements counter, branches on non-zero, flags untouched
// - displacement signed byte, added to address after the two-byte instruction
// - interrupt enable sets system mode bit zero, flags untouched
// - request pending while disabled is serviced once enable executes
// - enter: sp-2, push pointer, pointer=pc+1, pc=word at pointer, pointer+2
// - exit: pop pointer, sp+2, pc=word at pointer, pointer+2
// - idle stops the cpu clock, flags untouched
// - idle ends on interrupt request or external reset
// - byte increment sets zero, sign, overflow; others kept
// - word increment on even address pair, flags as byte increment
`timescale 1ns/1ps
`include "cid_params.svh"
module cid_core
    import cid_pkg::*;
#(
    parameter int RF_AW = 8
) (
    // clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // program memory word port
    output logic             pm_req_o,
    output logic      [15:0] pm_addr_o,
    input  wire logic        pm_ack_i,
    input  wire logic [15:0] pm_word_i,
    // interrupt and power
    input  wire logic        irq_req_i,
    input  wire logic        irq_ack_i,
    output logic             irq_service_o,
    output logic             cpu_clk_stop_o
);

    generate
        if (RF_AW != 8) begin : g_chk
            $error("cid_core: register addresses are eight bits");
        end
    endgenerate

    cid_state_t  state_reg;
    cid_instr_t  instr_reg;
    logic [7:0]  ea_reg;
    logic [7:0]  hi_reg;
    logic [7:0]  lo_reg;
    logic [15:0] pc_reg;
    logic [7:0]  sp_reg;
    logic [15:0] ip_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  win_reg;
    logic [7:0]  rf_addr_reg;
    logic        taken_reg;
    logic        badop_reg;
    logic        pm_req_reg;
    logic [15:0] pm_addr_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic        rf_pend_reg;
    logic        idle_reg;
    logic        irq_s1_reg;
    logic        irq_s2_reg;
    logic        pend_reg;
    logic        service_reg;

    logic        mem_we;
    logic [7:0]  mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [31:0] rd_mux;
    logic        addr_ok;
    logic        wr_commit;
    logic        ctrl_commit;
    logic        is_word;
    logic        is_loop;
    cid_alu_t    alu;
    logic [7:0]  dec_val;
    cid_instr_t  new_instr;

    function automatic cid_alu_t alu_inc(input logic [15:0] v, input logic word);
        cid_alu_t r;
        r.res  = word ? v + 16'h0001 : {8'h00, v[7:0] + 8'h01};
        r.zero = word ? (r.res == 16'h0000) : (r.res[7:0] == 8'h00);
        r.neg  = word ? r.res[15] : r.res[7];
        r.ovf  = word ? (r.res == 16'h8000) : (r.res[7:0] == 8'h80);
        return r;
    endfunction

    function automatic logic [7:0] wreg(input logic [7:0] win, input logic [3:0] idx);
        return win + {4'h0, idx};
    endfunction

    cid_regfile #(
        .AW (RF_AW),
        .DW (8)
    ) u_rf (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    assign new_instr   = pwdata_i[15:0];
    assign addr_ok     = (paddr_i[1:0] == 2'b00) && (paddr_i <= `CID_OFF_RFDATA);
    assign wr_commit   = psel_i && penable_i && pready_reg && pwrite_i && !pslverr_reg;
    assign ctrl_commit = wr_commit && (paddr_i == `CID_OFF_CTRL);
    assign is_word     = (instr_reg.op == `CID_OP_WORD_RR) || (instr_reg.op == `CID_OP_WORD_IR);
    assign is_loop     = (instr_reg.op[3:0] == `CID_NIB_LOOP);
    assign dec_val     = mem_rdata - 8'h01;
    assign alu         = alu_inc({hi_reg, mem_rdata}, is_word);

    // register file port: software while ready, sequencer otherwise
    always_comb begin
        mem_we    = 1'b0;
        mem_addr  = rf_addr_reg;
        mem_wdata = pwdata_i[7:0];
        unique case (state_reg)
            ST_READY:  mem_we = wr_commit && (paddr_i == `CID_OFF_RFDATA);
            ST_IND:    mem_addr = instr_reg.arg;
            ST_RD1:    mem_addr = ea_reg;
            ST_RD2:    mem_addr = ea_reg + 8'h01;
            ST_CALC: begin
                mem_we    = 1'b1;
                mem_addr  = ea_reg;
                mem_wdata = is_word ? alu.res[15:8] : (is_loop ? dec_val : alu.res[7:0]);
            end
            ST_WR2: begin
                mem_we    = 1'b1;
                mem_addr  = ea_reg + 8'h01;
                mem_wdata = lo_reg;
            end
            ST_PUSH1: begin
                mem_we    = 1'b1;
                mem_addr  = sp_reg - `CID_SP_STEP;
                mem_wdata = ip_reg[15:8];
            end
            ST_PUSH2: begin
                mem_we    = 1'b1;
                mem_addr  = sp_reg - 8'h01;
                mem_wdata = ip_reg[7:0];
            end
            ST_POP1:   mem_addr = sp_reg;
            ST_POP2:   mem_addr = sp_reg + 8'h01;
            default:   mem_addr = rf_addr_reg;
        endcase
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            `CID_OFF_CTRL:   rd_mux = {16'h0000, instr_reg};
            `CID_OFF_STATUS: begin
                rd_mux[`CID_ST_BUSY]  = (state_reg != ST_READY);
                rd_mux[`CID_ST_IDLE]  = idle_reg;
                rd_mux[`CID_ST_TAKEN] = taken_reg;
                rd_mux[`CID_ST_BADOP] = badop_reg;
                rd_mux[`CID_ST_PEND]  = pend_reg;
            end
            `CID_OFF_PC:     rd_mux = {16'h0000, pc_reg};
            `CID_OFF_SP:     rd_mux = {24'h000000, sp_reg};
            `CID_OFF_IP:     rd_mux = {16'h0000, ip_reg};
            `CID_OFF_FLAGS:  rd_mux = {24'h000000, flags_reg};
            `CID_OFF_MODE:   rd_mux = {24'h000000, mode_reg};
            `CID_OFF_WIN:    rd_mux = {24'h000000, win_reg};
            `CID_OFF_RFADDR: rd_mux = {24'h000000, rf_addr_reg};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // apb answer when ready, status any time: pready one cycle into access, two for register file reads
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            rf_pend_reg <= 1'b0;
        end else if (ce_i) begin
            if (pready_reg) begin
                pready_reg  <= 1'b0;
                pslverr_reg <= 1'b0;
            end else if (rf_pend_reg) begin
                rf_pend_reg <= 1'b0;
                pready_reg  <= 1'b1;
                prdata_reg  <= {24'h000000, mem_rdata};
            end else if (psel_i && penable_i &&
                         (state_reg == ST_READY || paddr_i == `CID_OFF_STATUS)) begin
                if (addr_ok && !pwrite_i && paddr_i == `CID_OFF_RFDATA) begin
                    rf_pend_reg <= 1'b1;
                end else begin
                    pready_reg  <= 1'b1;
                    prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_mux;
                    pslverr_reg <= !addr_ok || (pwrite_i && paddr_i == `CID_OFF_CTRL && idle_reg);
                end
            end
        end
    end

    // sequencer and architectural state
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg   <= ST_READY;
            instr_reg   <= '0;
            ea_reg      <= 8'h00;
            hi_reg      <= 8'h00;
            lo_reg      <= 8'h00;
            pc_reg      <= `CID_RST_PC;
            sp_reg      <= `CID_RST_SP;
            ip_reg      <= `CID_RST_IP;
            flags_reg   <= `CID_RST_FLAGS;
            mode_reg    <= `CID_RST_MODE;
            win_reg     <= `CID_RST_WIN;
            rf_addr_reg <= 8'h00;
            taken_reg   <= 1'b0;
            badop_reg   <= 1'b0;
            pm_req_reg  <= 1'b0;
            pm_addr_reg <= 16'h0000;
        end else if (ce_i) begin
            unique case (state_reg)
                ST_READY: begin
                    hi_reg <= 8'h00;
                    if (wr_commit) begin
                        unique case (paddr_i)
                            `CID_OFF_PC:     pc_reg      <= pwdata_i[15:0];
                            `CID_OFF_SP:     sp_reg      <= pwdata_i[7:0];
                            `CID_OFF_IP:     ip_reg      <= pwdata_i[15:0];
                            `CID_OFF_FLAGS:  flags_reg   <= pwdata_i[7:0];
                            `CID_OFF_MODE:   mode_reg    <= pwdata_i[7:0];
                            `CID_OFF_WIN:    win_reg     <= pwdata_i[7:0];
                            `CID_OFF_RFADDR: rf_addr_reg <= pwdata_i[7:0];
                            default:         ;
                        endcase
                    end
                    if (ctrl_commit) begin
                        instr_reg <= new_instr;
                        taken_reg <= 1'b0;
                        badop_reg <= 1'b0;
                        if (new_instr.op[3:0] == `CID_NIB_LOOP || new_instr.op[3:0] == `CID_NIB_INC) begin
                            ea_reg    <= wreg(win_reg, new_instr.op[7:4]);
                            state_reg <= ST_RD1;
                        end else begin
                            unique case (new_instr.op)
                                `CID_OP_INC_R: begin
                                    ea_reg    <= new_instr.arg;
                                    state_reg <= ST_RD1;
                                end
                                `CID_OP_WORD_RR: begin
                                    ea_reg    <= {new_instr.arg[7:1], 1'b0};
                                    state_reg <= ST_RD1;
                                end
                                `CID_OP_INC_IR,
                                `CID_OP_WORD_IR: state_reg <= ST_IND;
                                `CID_OP_ENTER:   state_reg <= ST_PUSH1;
                                `CID_OP_EXIT:    state_reg <= ST_POP1;
                                `CID_OP_IRQ_ON: begin
                                    mode_reg[`CID_MODE_IRQ_EN] <= 1'b1;
                                    pc_reg               <= pc_reg + `CID_LEN1;
                                end
                                `CID_OP_IDLE:    pc_reg <= pc_reg + `CID_LEN1;
                                default:         badop_reg <= 1'b1;
                            endcase
                        end
                    end
                end
                ST_IND:  state_reg <= ST_INDW;
                ST_INDW: begin
                    ea_reg    <= is_word ? {mem_rdata[7:1], 1'b0} : mem_rdata;
                    state_reg <= ST_RD1;
                end
                ST_RD1:  state_reg <= is_word ? ST_RD2 : ST_CALC;
                ST_RD2: begin
                    hi_reg    <= mem_rdata;
                    state_reg <= ST_CALC;
                end
                ST_CALC: begin
                    if (is_loop) begin
                        taken_reg <= (dec_val != 8'h00);
                        pc_reg    <= pc_reg + `CID_LEN2 +
                                     ((dec_val != 8'h00) ? {{8{instr_reg.arg[7]}}, instr_reg.arg} : 16'h0000);
                        state_reg <= ST_READY;
                    end else begin
                        flags_reg[`CID_FLG_Z] <= alu.zero;
                        flags_reg[`CID_FLG_S] <= alu.neg;
                        flags_reg[`CID_FLG_V] <= alu.ovf;
                        pc_reg    <= pc_reg + ((instr_reg.op[3:0] == `CID_NIB_INC) ? `CID_LEN1 : `CID_LEN2);
                        lo_reg    <= alu.res[7:0];
                        state_reg <= is_word ? ST_WR2 : ST_READY;
                    end
                end
                ST_WR2:  state_reg <= ST_READY;
                ST_PUSH1: state_reg <= ST_PUSH2;
                ST_PUSH2: begin
                    sp_reg      <= sp_reg - `CID_SP_STEP;
                    ip_reg      <= pc_reg + `CID_LEN1;
                    pm_req_reg  <= 1'b1;
                    pm_addr_reg <= pc_reg + `CID_LEN1;
                    state_reg   <= ST_PMWAIT;
                end
                ST_POP1: state_reg <= ST_POP2;
                ST_POP2: begin
                    hi_reg    <= mem_rdata;
                    state_reg <= ST_POP3;
                end
                ST_POP3: begin
                    ip_reg      <= {hi_reg, mem_rdata};
                    sp_reg      <= sp_reg + `CID_SP_STEP;
                    pm_req_reg  <= 1'b1;
                    pm_addr_reg <= {hi_reg, mem_rdata};
                    state_reg   <= ST_PMWAIT;
                end
                ST_PMWAIT: begin
                    if (pm_ack_i) begin
                        pm_req_reg <= 1'b0;
                        pc_reg     <= pm_word_i;
                        ip_reg     <= ip_reg + `CID_LEN2;
                        state_reg  <= ST_READY;
                    end
                end
                default: state_reg <= ST_READY;
            endcase
        end
    end

    // interrupt request synchroniser and pending latch
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_s1_reg  <= 1'b0;
            irq_s2_reg  <= 1'b0;
            pend_reg    <= 1'b0;
            service_reg <= 1'b0;
        end else if (ce_i) begin
            irq_s1_reg <= irq_req_i;
            irq_s2_reg <= irq_s1_reg;
            // set wins over acknowledge
            if (irq_s2_reg) begin
                pend_reg <= 1'b1;
            end else if (irq_ack_i) begin
                pend_reg <= 1'b0;
            end
            service_reg <= pend_reg && mode_reg[`CID_MODE_IRQ_EN] && !irq_ack_i;
        end
    end

    // idle mode
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            idle_reg <= 1'b0;
        end else if (ce_i) begin
            if (irq_s2_reg) begin
                idle_reg <= 1'b0;
            end else if (ctrl_commit && new_instr.op == `CID_OP_IDLE) begin
                idle_reg <= 1'b1;
            end
        end
    end

    assign prdata_o       = prdata_reg;
    assign pready_o       = pready_reg;
    assign pslverr_o      = pslverr_reg;
    assign pm_req_o       = pm_req_reg;
    assign pm_addr_o      = pm_addr_reg;
    assign irq_service_o  = service_reg;
    assign cpu_clk_stop_o = idle_reg;

endmodule // cid_core

/* cid_core_sva.sv */
// assertions on the instruction slice core ports
// assumes a bind into cid_core and a single clock domain
`timescale 1ns/1ps
`include "cid_params.svh"
module cid_core_sva (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // program memory, interrupt, power
    input wire logic        pm_req_o,
    input wire logic [15:0] pm_addr_o,
    input wire logic        pm_ack_i,
    input wire logic        irq_req_i,
    input wire logic        irq_ack_i,
    input wire logic        irq_service_o,
    input wire logic        cpu_clk_stop_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_rdy_one;
        pready_o |=> !pready_o;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
    property p_rdy_acc;
        pready_o |-> psel_i && penable_i;
    endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access phase");
    property p_err_rdy;
        pslverr_o |-> pready_o;
    endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_pm_hold;
        pm_req_o && !pm_ack_i |=> pm_req_o && $stable(pm_addr_o);
    endproperty
    a_pm_hold: assert property (p_pm_hold) else $error("fetch dropped or moved");
    property p_pm_done;
        pm_req_o && pm_ack_i |=> !pm_req_o;
    endproperty
    a_pm_done: assert property (p_pm_done) else $error("fetch kept after ack");
    property p_idle_in;
        $rose(cpu_clk_stop_o) |-> $past(pready_o && pwrite_i && paddr_i == `CID_OFF_CTRL
            && pwdata_i[7:0] == `CID_OP_IDLE);
    endproperty
    a_idle_in: assert property (p_idle_in) else $error("clock stop without idle");
    property p_idle_out;
        cpu_clk_stop_o && irq_req_i |-> ##[0:4] !cpu_clk_stop_o;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle kept after request");
    property p_srv_hold;
        $fell(irq_service_o) |-> $past(irq_ack_i) || $past(pready_o && pwrite_i);
    endproperty
    a_srv_hold: assert property (p_srv_hold) else $error("service dropped unacked");
endmodule // cid_core_sva

bind cid_core cid_core_sva u_sva (.*);

/* cid_pm_model.sv */
// program memory stand-in answering word fetches
// assumes the core holds request and address until ack
`timescale 1ns/1ps
module cid_pm_model #(
    parameter logic [15:0] KEY = 16'h5A3C
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // word port
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    output logic             ack_o,
    output logic      [15:0] word_o
);
    logic [2:0] wait_reg;
    logic       slow_reg;
    // prompt and slow answers alternate; data churns outside ack
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_o    <= 1'b0;
            word_o   <= 16'hFFFF;
            wait_reg <= 3'h0;
            slow_reg <= 1'b0;
        end else if (ack_o || !req_i) begin
            ack_o    <= 1'b0;
            word_o   <= ~word_o;
            wait_reg <= 3'h0;
            slow_reg <= slow_reg ^ ack_o;
        end else if (wait_reg >= (slow_reg ? 3'h5 : 3'h0)) begin
            ack_o  <= 1'b1;
            word_o <= addr_i ^ KEY;
        end else begin
            wait_reg <= wait_reg + 3'h1;
            word_o   <= ~word_o;
        end
    end
endmodule // cid_pm_model

/* cpu_instr_decrement_branch_nonzero_to_add_one_word_test.sv */
// self-checking bench for the instruction slice core
// assumes cid_core, its checker and the program memory model
`timescale 1ns/1ps
`include "cid_params.svh"
module cpu_instr_decrement_branch_nonzero_to_add_one_word_test;
    localparam logic [15:0] KEY = 16'h5A3C;
    logic        mclk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, irq_req_i = 1'b0, irq_ack_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, err;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, q, hold;
    logic        pready_o, pslverr_o, pm_req_o, pm_ack_i, irq_service_o, cpu_clk_stop_o;
    logic [15:0] pm_addr_o, pm_word_i;
    int          errors = 0, total_checks = 0;
    always #5 mclk_i = ~mclk_i;
    cid_core uut (.*);
    cid_pm_model #(.KEY(KEY)) pm (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(pm_req_o), .addr_i(pm_addr_o),
        .ack_o(pm_ack_i), .word_o(pm_word_i));
    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 100);
        q = prdata_o;
        err = pslverr_o;
        if (n >= 100) begin
            errors++;
            results();
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic rf(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, `CID_OFF_RFADDR, {24'h0, a});
        apb(1'b1, `CID_OFF_RFDATA, {24'h0, d});
    endtask
    task automatic rfc(input logic [7:0] a, input logic [7:0] e, input string n);
        apb(1'b1, `CID_OFF_RFADDR, {24'h0, a});
        rc(`CID_OFF_RFDATA, {24'h0, e}, n);
    endtask
    task automatic op(input logic [15:0] c);
        apb(1'b1, `CID_OFF_CTRL, {16'h0, c});
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        for (int i = 0; i < 5; i++) rc(`CID_OFF_PC + 8'(4 * i), 32'h0, "reset value");
        rc(8'h40, 32'h0, "unmapped read");
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");
        apb(1'b1, `CID_OFF_WIN, 32'hC0);
        apb(1'b1, `CID_OFF_FLAGS, 32'h8F);
        apb(1'b1, `CID_OFF_PC, 32'h0100);
        rf(8'hC1, 8'h02);
        op(16'h801A);
        rc(`CID_OFF_PC, 32'h0082, "pc back");
        op(16'h7F1A);
        rfc(8'hC1, 8'h00, "counter");
        rc(`CID_OFF_PC, 32'h0084, "pc fall");
        rf(8'hC1, 8'h05);
        op(16'h7F1A);
        rc(`CID_OFF_PC, 32'h0105, "pc fwd");
        rc(`CID_OFF_STATUS, 32'h04, "taken");
        rc(`CID_OFF_FLAGS, 32'h8F, "loop flags");
        op(16'h0055);
        rc(`CID_OFF_STATUS, 32'h08, "bad opcode");
        $display("test loop done");
        rf(8'hC3, 8'h7F);
        op(16'h003E);
        rfc(8'hC3, 8'h80, "inc r");
        rc(`CID_OFF_FLAGS, 32'hBF, "inc flags");
        rf(8'h41, 8'h42);
        rf(8'h42, 8'hFF);
        op(16'h4121);
        rfc(8'h42, 8'h00, "inc ir");
        rc(`CID_OFF_FLAGS, 32'hCF, "inc zero");
        rf(8'h10, 8'hFF);
        rf(8'h11, 8'hFF);
        op(16'h10A0);
        rfc(8'h10, 8'h00, "wrap hi");
        hold = q;
        rfc(8'h11, 8'h00, "wrap lo");
        chk("wrap or", 32'h0, hold | q);
        rc(`CID_OFF_FLAGS, 32'hCF, "wrap flags");
        rf(8'h10, 8'h7F);
        rf(8'h11, 8'hFF);
        op(16'h10A0);
        rfc(8'h10, 8'h80, "add_one_word hi");
        rfc(8'h11, 8'h00, "add_one_word lo");
        rc(`CID_OFF_FLAGS, 32'hBF, "add_one_word flags");
        $display("test increment done");
        apb(1'b1, `CID_OFF_SP, 32'h80);
        apb(1'b1, `CID_OFF_IP, 32'h1234);
        apb(1'b1, `CID_OFF_PC, 32'h0200);
        op({8'h00, `CID_OP_ENTER});
        rc(`CID_OFF_SP, 32'h7E, "sp enter");
        rfc(8'h7E, 8'h12, "push hi");
        rfc(8'h7F, 8'h34, "push lo");
        rc(`CID_OFF_PC, {16'h0, 16'h0201 ^ KEY}, "pc enter");
        rc(`CID_OFF_IP, 32'h0203, "ip enter");
        op({8'h00, `CID_OP_EXIT});
        rc(`CID_OFF_SP, 32'h80, "sp exit");
        rc(`CID_OFF_PC, {16'h0, 16'h1234 ^ KEY}, "pc exit");
        rc(`CID_OFF_IP, 32'h1236, "ip exit");
        rc(`CID_OFF_FLAGS, 32'hBF, "thread flags");
        $display("test thread done");
        irq_req_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk("service off", 32'h0, {31'h0, irq_service_o});
        op({8'h00, `CID_OP_IRQ_ON});
        @(negedge mclk_i);
        chk("service on", 32'h1, {31'h0, irq_service_o});
        @(posedge mclk_i);
        rc(`CID_OFF_MODE, 32'h01, "mode reg");
        irq_req_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        ce_i <= 1'b0;
        irq_ack_i <= 1'b1;
        @(posedge mclk_i);
        ce_i <= 1'b1;
        irq_ack_i <= 1'b0;
        @(negedge mclk_i);
        chk("frozen", 32'h1, {31'h0, irq_service_o});
        @(posedge mclk_i);
        irq_ack_i <= 1'b1;
        @(posedge mclk_i);
        irq_ack_i <= 1'b0;
        op({8'h00, `CID_OP_IDLE});
        @(negedge mclk_i);
        chk("idle", 32'h1, {31'h0, cpu_clk_stop_o});
        @(posedge mclk_i);
        rc(`CID_OFF_FLAGS, 32'hBF, "idle flags");
        rc(`CID_OFF_STATUS, 32'h02, "status idle");
        op({8'h00, `CID_OP_IRQ_ON});
        chk("refused", 32'h1, {31'h0, err});
        irq_req_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("wake", 32'h0, {31'h0, cpu_clk_stop_o});
        $display("test irq idle done");
        results();
    end
endmodule // cpu_instr_decrement_branch_nonzero_to_add_one_word_test
